// File: rtl/mode_decode_if.sv
`timescale 1ns/1ps
interface mode_decode_if;
  import mode_zero_pkg::*;
  logic [ADDR_WIDTH-1:0] addr;
  logic [SELECT_WIDTH-1:0] select;
  recovery_type recovery;
  logic [CAS_WIDTH-1:0] cas_code;
  logic burst_reserved;
  logic control_word;

  modport decoder (
    input addr,
    input select,
    output recovery,
    output cas_code,
    output burst_reserved,
    output control_word
  );
  modport user (
    output addr,
    output select,
    input recovery,
    input cas_code,
    input burst_reserved,
    input control_word
  );
endinterface

// File: rtl/mode_field_decode.sv
`timescale 1ns/1ps
module mode_field_decode
  import mode_zero_pkg::*;
#(
  parameter bit HAS_RECOVERY_HIGH = 1'b1,
  parameter bit HAS_CAS_HIGH = 1'b1
)
(
  mode_decode_if.decoder dec
);

  wire recovery_high;
  wire cas_high;
  wire [3:0] recovery_code;

  // lower-density parts may leave the top bits unimplemented
  assign recovery_high = HAS_RECOVERY_HIGH & dec.addr[POS_RECOVERY_HIGH];
  assign cas_high = HAS_CAS_HIGH & dec.addr[POS_CAS_HIGH];
  assign recovery_code = {recovery_high, dec.addr[POS_RECOVERY_MSB:POS_RECOVERY_LSB]};
  assign dec.recovery = decode_recovery(recovery_code);
  assign dec.cas_code = {cas_high, dec.addr[POS_CAS_MSB:POS_CAS_LSB],
    dec.addr[POS_CAS_LOW]};
  assign dec.burst_reserved = dec.addr[POS_BURST_MSB:POS_BURST_LSB] == BURST_RESERVED;
  assign dec.control_word = dec.select == SELECT_CONTROL_WORD;

endmodule

// File: rtl/mode_zero_pkg.sv
package mode_zero_pkg;

  localparam int ADDR_WIDTH = 18;
  localparam int CYCLE_WIDTH = 5;
  localparam int CAS_WIDTH = 5;
  localparam int SELECT_WIDTH = 3;
  localparam int MODE_COUNT = 7;
  localparam int PERIOD_WIDTH = 8;
  localparam int DELAY_WIDTH = 9;

  // address field positions
  localparam int POS_RESERVED_TOP = 17;
  localparam int POS_RECOVERY_HIGH = 13;
  localparam int POS_CAS_HIGH = 12;
  localparam int POS_RECOVERY_MSB = 11;
  localparam int POS_RECOVERY_LSB = 9;
  localparam int POS_DLL_RESET = 8;
  localparam int POS_TEST_MODE = 7;
  localparam int POS_CAS_MSB = 6;
  localparam int POS_CAS_LSB = 4;
  localparam int POS_BURST_TYPE = 3;
  localparam int POS_CAS_LOW = 2;
  localparam int POS_BURST_MSB = 1;
  localparam int POS_BURST_LSB = 0;

  // mode register select codes
  localparam logic [SELECT_WIDTH-1:0] SELECT_ZERO = 3'h0;
  localparam logic [SELECT_WIDTH-1:0] SELECT_LAST = 3'h6;
  localparam logic [SELECT_WIDTH-1:0] SELECT_CONTROL_WORD = 3'h7;

  // burst length codes
  localparam logic [1:0] BURST_EIGHT_FIXED = 2'h0;
  localparam logic [1:0] BURST_PER_COMMAND = 2'h1;
  localparam logic [1:0] BURST_CHOP_FOUR = 2'h2;
  localparam logic [1:0] BURST_RESERVED = 2'h3;

  // reset values
  localparam logic [ADDR_WIDTH-1:0] RESET_CONFIG = 18'h00000;
  localparam logic [CYCLE_WIDTH-1:0] RESET_WRITE_RECOVERY = 5'h0A;
  localparam logic [CYCLE_WIDTH-1:0] RESET_READ_PRECHARGE = 5'h05;
  localparam logic [CYCLE_WIDTH-1:0] CYCLES_RESERVED = 5'h00;

  typedef struct packed {
    logic [CYCLE_WIDTH-1:0] write_recovery;
    logic [CYCLE_WIDTH-1:0] read_to_precharge_cycles;
    logic reserved;
  } recovery_type;

  // recovery code table, write / read-to-precharge clocks
  function automatic recovery_type decode_recovery(input logic [3:0] code);
    recovery_type r;
    r.reserved = 1'b0;
    r.write_recovery = CYCLES_RESERVED;
    r.read_to_precharge_cycles = CYCLES_RESERVED;
    case (code)
      4'h0: begin r.write_recovery = 5'h0A; r.read_to_precharge_cycles = 5'h05; end
      4'h1: begin r.write_recovery = 5'h0C; r.read_to_precharge_cycles = 5'h06; end
      4'h2: begin r.write_recovery = 5'h0E; r.read_to_precharge_cycles = 5'h07; end
      4'h3: begin r.write_recovery = 5'h10; r.read_to_precharge_cycles = 5'h08; end
      4'h4: begin r.write_recovery = 5'h12; r.read_to_precharge_cycles = 5'h09; end
      4'h5: begin r.write_recovery = 5'h14; r.read_to_precharge_cycles = 5'h0A; end
      4'h6: begin r.write_recovery = 5'h18; r.read_to_precharge_cycles = 5'h0C; end
      4'h7: begin r.write_recovery = 5'h16; r.read_to_precharge_cycles = 5'h0B; end
      4'h8: begin r.write_recovery = 5'h1A; r.read_to_precharge_cycles = 5'h0D; end
      default: r.reserved = 1'b1;
    endcase
    return r;
  endfunction

endpackage

// File: rtl/sdram_mode_register_zero_decode.sv
`timescale 1ns/1ps
module sdram_mode_register_zero_decode
  import mode_zero_pkg::*;
#(
  parameter bit HAS_RECOVERY_HIGH = 1'b1,
  parameter bit HAS_CAS_HIGH = 1'b1
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // mode-set command, sampled on the command clock
  input wire logic mode_set_command_i,
  input wire logic [1:0] bank_group_i,
  input wire logic [1:0] bank_i,
  input wire logic [ADDR_WIDTH-1:0] addr_i,
  // timing input from the precharge logic
  input wire logic [PERIOD_WIDTH-1:0] precharge_period_i,
  // held mode register zero contents
  output logic [ADDR_WIDTH-1:0] mode_config_zero_o,
  output logic [CYCLE_WIDTH-1:0] write_recovery_o,
  output logic [CYCLE_WIDTH-1:0] read_to_precharge_cycles_o,
  output logic recovery_reserved_o,
  output logic [CAS_WIDTH-1:0] cas_code_o,
  output logic test_mode_select_o,
  output logic burst_interleave_o,
  output logic [1:0] burst_length_o,
  output logic burst_reserved_o,
  output logic [DELAY_WIDTH-1:0] autoprecharge_write_delay_o,
  // events
  output logic dll_reset_o,
  output logic [MODE_COUNT-1:0] mode_write_o
);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  mode_decode_if dec ();

  wire [SELECT_WIDTH-1:0] select_code;
  wire accept_write;
  wire write_zero;
  wire [MODE_COUNT-1:0] next_mode_write;

  // bank_group_i[1] and addr_i[17] are expected low; they are not checked
  assign select_code = {bank_group_i[0], bank_i};
  assign dec.select = select_code;
  assign dec.addr = addr_i;
  // control-word slot gets no strobe and no capture
  assign accept_write = mode_set_command_i & ~dec.control_word;
  assign write_zero = accept_write & (select_code == SELECT_ZERO);
  assign next_mode_write = accept_write ? MODE_COUNT'(1 << select_code) : '0;

  mode_field_decode #(
    .HAS_RECOVERY_HIGH(HAS_RECOVERY_HIGH),
    .HAS_CAS_HIGH(HAS_CAS_HIGH)
  ) u_decode (
    .dec(dec)
  );

  // ----------------------------------------------------------------
  // register capture
  // ----------------------------------------------------------------
  // every field moves in the same edge so no mixed setting is ever visible
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_config_zero_o <= RESET_CONFIG;
      write_recovery_o <= RESET_WRITE_RECOVERY;
      read_to_precharge_cycles_o <= RESET_READ_PRECHARGE;
      recovery_reserved_o <= 1'b0;
      cas_code_o <= '0;
      test_mode_select_o <= 1'b0;
      burst_interleave_o <= 1'b0;
      burst_length_o <= BURST_EIGHT_FIXED;
      burst_reserved_o <= 1'b0;
    end
    else if (write_zero)
    begin
      mode_config_zero_o <= addr_i;
      write_recovery_o <= dec.recovery.write_recovery;
      read_to_precharge_cycles_o <= dec.recovery.read_to_precharge_cycles;
      recovery_reserved_o <= dec.recovery.reserved;
      cas_code_o <= dec.cas_code;
      test_mode_select_o <= addr_i[POS_TEST_MODE];
      burst_interleave_o <= addr_i[POS_BURST_TYPE];
      burst_length_o <= addr_i[POS_BURST_MSB:POS_BURST_LSB];
      burst_reserved_o <= dec.burst_reserved;
    end
  end

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  // delay-line reset is an action, not a state: one pulse per register-zero write with addr_i[8] set
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dll_reset_o <= 1'b0;
      mode_write_o <= '0;
    end
    else
    begin
      dll_reset_o <= write_zero & addr_i[POS_DLL_RESET];
      mode_write_o <= next_mode_write;
    end
  end

  // ----------------------------------------------------------------
  // autoprecharge write delay
  // ----------------------------------------------------------------
  // follows one edge behind a write or a period change
  wire [DELAY_WIDTH-1:0] next_delay;
  assign next_delay = DELAY_WIDTH'(write_recovery_o) + DELAY_WIDTH'(precharge_period_i);

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      autoprecharge_write_delay_o <= DELAY_WIDTH'(RESET_WRITE_RECOVERY);
    else
      autoprecharge_write_delay_o <= next_delay;
  end

endmodule

// File: verif/mode_set_controller.sv
`timescale 1ns/1ps
module mode_set_controller
  import mode_zero_pkg::*;
#(
  parameter int GAP = 0
)
(
  // clock
  input wire logic clk_i,
  // command lines
  output logic cmd_o = 1'b0,
  output logic [1:0] bg_o = 2'h0,
  output logic [1:0] ba_o = 2'h0,
  output logic [ADDR_WIDTH-1:0] addr_o = 18'h00000
);
  // ----
  // command issue
  // ----
  // field codes come from the caller, reserved ones only on purpose
  task automatic issue(input logic [2:0] sel, input logic [ADDR_WIDTH-1:0] a);
    repeat (GAP) @(posedge clk_i);
    @(posedge clk_i);
    cmd_o <= 1'b1;
    bg_o <= {1'b0, sel[2]};
    ba_o <= sel[1:0];
    addr_o <= {1'b0, a[ADDR_WIDTH-2:0]};
    @(posedge clk_i);
    cmd_o <= 1'b0;
    // address lines do not keep the last value once taken; bank lines do
    addr_o <= ~addr_o;
  endtask
endmodule

// File: verif/sdram_mode_register_zero_decode_monitor.sv
`timescale 1ns/1ps
module sdram_mode_register_zero_decode_monitor
  import mode_zero_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // command
  input wire logic mode_set_command_i,
  input wire logic [1:0] bank_group_i,
  input wire logic [1:0] bank_i,
  input wire logic [ADDR_WIDTH-1:0] addr_i,
  input wire logic [PERIOD_WIDTH-1:0] precharge_period_i,
  // decoded
  input wire logic [ADDR_WIDTH-1:0] mode_config_zero_o,
  input wire logic [CYCLE_WIDTH-1:0] write_recovery_o,
  input wire logic recovery_reserved_o,
  input wire logic [CAS_WIDTH-1:0] cas_code_o,
  input wire logic test_mode_select_o,
  input wire logic burst_interleave_o,
  input wire logic [1:0] burst_length_o,
  input wire logic [DELAY_WIDTH-1:0] autoprecharge_write_delay_o,
  input wire logic dll_reset_o,
  input wire logic [MODE_COUNT-1:0] mode_write_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire logic [2:0] sel = {bank_group_i[0], bank_i};
  wire logic hit = mode_set_command_i && sel == 3'h0;
  wire logic dll_req = hit && addr_i[8];
  wire logic [3:0] rcode = {addr_i[13], addr_i[11:9]};
  wire logic [4:0] cas_in = {addr_i[12], addr_i[6:4], addr_i[2]};
  wire logic [3:0] mode_in = {addr_i[7], addr_i[3], addr_i[1:0]};
  wire logic [6:0] strobe = mode_set_command_i && sel != 3'h7 ? 7'h01 << sel : 7'h00;
  property p_strobe; 1'b1 |=> mode_write_o == $past(strobe); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe");
  property p_hold; !hit |=> $stable(mode_config_zero_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_cap; hit |=> mode_config_zero_o == $past(addr_i); endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_rec; hit |=> recovery_reserved_o == ($past(rcode) > 4'h8); endproperty
  a_rec: assert property (p_rec) else $error("recovery");
  // the release edge itself still loads the reset value, so start only once out of reset
  property p_delay;
    resetn_i |=> autoprecharge_write_delay_o == $past(write_recovery_o) + $past(precharge_period_i);
  endproperty
  a_delay: assert property (p_delay) else $error("delay");
  property p_cas; hit |=> cas_code_o == $past(cas_in); endproperty
  a_cas: assert property (p_cas) else $error("cas");
  property p_mode;
    hit |=> {test_mode_select_o, burst_interleave_o, burst_length_o} == $past(mode_in);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits");
  property p_dll; 1'b1 |=> dll_reset_o == $past(dll_req); endproperty
  a_dll: assert property (p_dll) else $error("dll");
  c_dll: cover property (dll_req);
  c_word: cover property (mode_set_command_i && sel == 3'h7);
  c_rres: cover property (hit && rcode > 4'h8);
endmodule
bind sdram_mode_register_zero_decode sdram_mode_register_zero_decode_monitor mon (.*);

// File: verif/sdram_mode_register_zero_decode_tb.sv
`timescale 1ns/1ps
module sdram_mode_register_zero_decode_tb;
  import mode_zero_pkg::*;
  logic ref_clk_i;
  logic resetn_i;
  logic [7:0] precharge_period_i;
  wire logic mode_set_command_i;
  wire logic [1:0] bank_group_i, bank_i;
  wire logic [17:0] addr_i;
  logic [17:0] mode_config_zero_o;
  logic [4:0] write_recovery_o, read_to_precharge_cycles_o, cas_code_o;
  logic recovery_reserved_o, test_mode_select_o, burst_interleave_o, burst_reserved_o;
  logic dll_reset_o;
  logic [1:0] burst_length_o;
  logic [8:0] autoprecharge_write_delay_o;
  logic [6:0] mode_write_o;
  int err_count = 0;
  int cmp_count = 0;
  // ----
  // harness
  // ----
  mode_set_controller ctl (.clk_i(ref_clk_i), .cmd_o(mode_set_command_i), .bg_o(bank_group_i),
    .ba_o(bank_i), .addr_o(addr_i));
  sdram_mode_register_zero_decode dut (.*);
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_reset;
    @(negedge ref_clk_i);
    check("wr", 18'h0000A, 18'(write_recovery_o));
    check("read_precharge", 18'h00005, 18'(read_to_precharge_cycles_o));
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check("delay", 18'h0000A + 18'(precharge_period_i), 18'(autoprecharge_write_delay_o));
    $display("test reset done");
  endtask
  task automatic t_recovery;
    int e;
    for (int c = 0; c < 16; c++)
    begin
      @(posedge ref_clk_i);
      precharge_period_i <= 8'(c * 7);
      e = c < 6 ? 2 * c + 10 : c == 6 ? 24 : c == 7 ? 22 : c == 8 ? 26 : 0;
      ctl.issue(3'h0, {4'h0, c[3], 1'b0, c[2:0], 9'h000});
      @(negedge ref_clk_i);
      check("wr", 18'(e), 18'(write_recovery_o));
      check("read_precharge", 18'(e / 2), 18'(read_to_precharge_cycles_o));
      check("rres", 18'(c > 8), 18'(recovery_reserved_o));
      @(negedge ref_clk_i);
      check("delay", 18'(e + c * 7), 18'(autoprecharge_write_delay_o));
    end
    $display("test recovery done");
  endtask
  task automatic t_fields;
    logic [17:0] a;
    logic [17:0] pat [4] = '{18'h01174, 18'h000A9, 18'h0104E, 18'h0018B};
    for (int i = 0; i < 4; i++)
    begin
      a = pat[i];
      ctl.issue(3'h0, a);
      @(negedge ref_clk_i);
      check("cfg", a, mode_config_zero_o);
      check("cas", 18'({a[12], a[6:4], a[2]}), 18'(cas_code_o));
      check("bits", 18'({a[8], a[7], a[3], a[1:0]}),
        18'({dll_reset_o, test_mode_select_o, burst_interleave_o, burst_length_o}));
      check("bres", 18'(a[1:0] == 2'h3), 18'(burst_reserved_o));
    end
    $display("test fields done");
  endtask
  task automatic t_select;
    logic [17:0] a;
    logic [17:0] kept;
    kept = 18'h00000;
    for (int s = 0; s < 8; s++)
    begin
      a = 18'h0A5A0 + 18'(s);
      if (s == 0)
        kept = a;
      ctl.issue(3'(s), a);
      @(negedge ref_clk_i);
      check("strobe", s == 7 ? 18'h00000 : 18'h00001 << s, 18'(mode_write_o));
      check("cfg", kept, mode_config_zero_o);
    end
    $display("test select done");
  endtask
  // reset in mid-run must drop held fields, and a command right after release must land
  task automatic t_midreset;
    ctl.issue(3'h0, 18'h0DFFF);
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    @(negedge ref_clk_i);
    check("cfg", RESET_CONFIG, mode_config_zero_o);
    check("wr", 18'h0000A, 18'(write_recovery_o));
    check("tmode", 18'h00000, 18'(test_mode_select_o));
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(negedge ref_clk_i);
    check("delay", 18'h0000A, 18'(autoprecharge_write_delay_o));
    ctl.issue(3'h0, 18'h00801);
    @(negedge ref_clk_i);
    check("cfg", 18'h00801, mode_config_zero_o);
    check("wr", 18'h00012, 18'(write_recovery_o));
    check("strobe", 18'h00001, 18'(mode_write_o));
    $display("test mid-run reset done");
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    resetn_i = 1'b0;
    precharge_period_i = 8'h0D;
    repeat (12) @(posedge ref_clk_i);
    t_reset();
    t_recovery();
    t_fields();
    t_select();
    t_midreset();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
